// ==== src/ugrc_pkg.sv ====
// Package: register map, field positions and action timing for the global reset control block
//
// Contract
// - Bits 10:6 hold a writable selector choosing which transmit FIFOs get flushed.
// - Host mode: 0 non-periodic, 1 periodic, top bit both, others none.
// - Device mode: 0..3 flush that FIFO, top bit all, others none.
// - Bit 5 starts transmit flush; hardware clears it when finished.
// - Bit 4 flushes receive FIFO; hardware clears it when finished.
// - Host only: bit 2 clears frame counter; hardware clears bit afterwards.
// - Bit 1 resets bus-domain circuitry; hardware clears bit afterwards.
// - Bit 0 soft-resets core, both domains and most registers.
package ugrc_pkg;
    localparam logic [11:0] UGRC_GLOBAL_RESET_CONTROL_OFS = 12'h010;
    localparam int UGRC_SEL_LSB = 6;
    localparam int UGRC_SEL_MSB = 10;
    localparam int UGRC_TXF_BIT = 5;
    localparam int UGRC_RXF_BIT = 4;
    localparam int UGRC_HFC_BIT = 2;
    localparam int UGRC_BDR_BIT = 1;
    localparam int UGRC_CSR_BIT = 0;
    localparam logic [4:0] UGRC_SEL_RESET = 5'h00;
    localparam logic [4:0] UGRC_SEL_NONPER = 5'h00;
    localparam logic [4:0] UGRC_SEL_PER = 5'h01;
    localparam logic [4:0] UGRC_SEL_DEV_MAX = 5'h03;
    localparam int UGRC_NUM_DEV_TXF = 4;
    // Handshake timeout: completion acks that never come are forced after this many cycles
    localparam int UGRC_ACK_TIMEOUT_CYC = 255;
    localparam int UGRC_NUM_ACT = 5;
endpackage

// ==== src/ugrc_action.sv ====
// One self-clearing trigger: request pulse, busy flag, done on ack or timeout
`timescale 1ns/1ps
`default_nettype none
module ugrc_action (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Control
    input wire logic start,
    input wire logic ack,
    // Status
    output logic busy,
    output logic startPulse
);
    import ugrc_pkg::*;

    logic busy_r;
    logic pulse_r;
    logic [7:0] cnt_r;

    assign busy = busy_r;
    assign startPulse = pulse_r;

    // Start ignored while busy so a second write cannot restart a flush
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            busy_r <= 1'b0;
        end else if (!busy_r && start) begin
            busy_r <= 1'b1;
        end else if (busy_r && !pulse_r && (ack || cnt_r == 8'(UGRC_ACK_TIMEOUT_CYC))) begin
            busy_r <= 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            pulse_r <= 1'b0;
        end else begin
            pulse_r <= !busy_r && start;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n || !busy_r) begin
            cnt_r <= 8'h00;
        end else if (cnt_r != 8'hFF) begin
            cnt_r <= cnt_r + 8'h01;
        end
    end
endmodule // ugrc_action
`default_nettype wire

// ==== src/ugrc_core.sv ====
// Global reset control register: flush and soft-reset triggers with completion handshake
`timescale 1ns/1ps
`default_nettype none
module ugrc_core (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Register port
    input wire logic [11:0] addr,
    input wire logic [31:0] wrData,
    input wire logic wrStb,
    input wire logic rdStb,
    output logic [31:0] rdData,
    // Mode
    input wire logic hostMode,
    // Completion acks from the targeted logic
    input wire logic txFlushDone,
    input wire logic rxFlushDone,
    input wire logic frameClearDone,
    input wire logic busResetDone,
    input wire logic coreResetDone,
    // Action requests, one-cycle pulses
    output logic hostNonPerFlush,
    output logic hostPerFlush,
    output logic [3:0] devTxFifoFlush,
    output logic rxFlushReq,
    output logic frameClearReq,
    output logic busResetReq,
    output logic coreResetReq
);
    import ugrc_pkg::*;

    // =====================================================================
    // Local constants
    // =====================================================================
    // Action slots are packed; reserved bit 3 of the register has no slot
    // Slot order follows the register bit order with bit 3 squeezed out
    localparam int ACT_CSR = 0;
    localparam int ACT_BDR = 1;
    localparam int ACT_HFC = 2;
    localparam int ACT_RX = 3;
    localparam int ACT_TX = 4;
    // Top selector bit picks every FIFO in both modes
    localparam int SEL_TOP = UGRC_SEL_MSB - UGRC_SEL_LSB;

    // =====================================================================
    // Register decode
    // =====================================================================
    logic hit;
    logic wrHit;
    logic rdHit;
    logic [4:0] txSel_r;
    logic [4:0] startVec;
    logic [4:0] ackVec;
    logic [4:0] busyVec;
    logic [4:0] pulseVec;
    logic [31:0] rdWord;
    logic [31:0] rdData_r;

    assign hit = (addr == UGRC_GLOBAL_RESET_CONTROL_OFS);
    assign wrHit = wrStb && hit;
    assign rdHit = rdStb && hit;

    // Selector stored as written; a write during a tx flush only steers the next one
    // Core soft reset returns the selector to its reset value
    always_ff @(posedge clock) begin
        if (!rst_n || pulseVec[ACT_CSR]) begin
            txSel_r <= UGRC_SEL_RESET;
        end else if (wrHit) begin
            txSel_r <= wrData[UGRC_SEL_MSB:UGRC_SEL_LSB];
        end
    end

    // Only ones written start an action; zeros leave running actions alone
    always_comb begin
        startVec = '0;
        if (wrHit) begin
            startVec[ACT_TX] = wrData[UGRC_TXF_BIT];
            startVec[ACT_RX] = wrData[UGRC_RXF_BIT];
            startVec[ACT_HFC] = wrData[UGRC_HFC_BIT] && hostMode;
            startVec[ACT_BDR] = wrData[UGRC_BDR_BIT];
            startVec[ACT_CSR] = wrData[UGRC_CSR_BIT];
        end
    end

    // =====================================================================
    // Completion acks
    // =====================================================================
    // Slot order: tx, rx, frame clear, bus reset, core reset
    // Acks arriving before the request pulse leaves are ignored by the sequencer
    assign ackVec = {txFlushDone, rxFlushDone, frameClearDone, busResetDone, coreResetDone};

    // =====================================================================
    // Trigger bits, one sequencer per bit
    // =====================================================================
    // A start seen while busy is dropped, so a repeated write cannot restart an action
    // The timeout in each sequencer keeps a missing ack from hanging software polling
    genvar gi;
    generate
        for (gi = 0; gi < UGRC_NUM_ACT; gi++) begin : g_act
            ugrc_action u_act (
                .clock(clock),
                .rst_n(rst_n),
                .start(startVec[gi]),
                .ack(ackVec[gi]),
                .busy(busyVec[gi]),
                .startPulse(pulseVec[gi])
            );
        end
    endgenerate

    // =====================================================================
    // Transmit FIFO selection
    // =====================================================================
    logic txGo;
    logic hostNonPerSel;
    logic hostPerSel;
    wire logic [3:0] devSel;

    assign txGo = pulseVec[ACT_TX];

    // Mode is sampled with the pulse; software keeps it steady while a flush is pending
    // Host: 00000 non-periodic, 00001 periodic, 1xxxx both, anything else none
    assign hostNonPerSel = txSel_r[SEL_TOP] || (txSel_r == UGRC_SEL_NONPER);
    assign hostPerSel = txSel_r[SEL_TOP] || (txSel_r == UGRC_SEL_PER);

    // Device: an index past the last FIFO with the top bit clear matches nothing, so it flushes nothing
    genvar fi;
    generate
        for (fi = 0; fi < UGRC_NUM_DEV_TXF; fi++) begin : g_dev
            assign devSel[fi] = txSel_r[SEL_TOP] ||
                ((txSel_r == 5'(fi)) && (5'(fi) <= UGRC_SEL_DEV_MAX));
        end
    endgenerate

    // =====================================================================
    // Request pulses, registered so every output leaves a flip-flop
    // =====================================================================
    // Requests leave two edges after the write, decoded from the selector held then
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            hostNonPerFlush <= 1'b0;
        end else begin
            hostNonPerFlush <= txGo && hostMode && hostNonPerSel;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            hostPerFlush <= 1'b0;
        end else begin
            hostPerFlush <= txGo && hostMode && hostPerSel;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            devTxFifoFlush <= 4'h0;
        end else begin
            devTxFifoFlush <= (txGo && !hostMode) ? devSel : 4'h0;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            rxFlushReq <= 1'b0;
        end else begin
            rxFlushReq <= pulseVec[ACT_RX];
        end
    end

    // Frame clear starts only in host mode, so this pulse never fires in device mode
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            frameClearReq <= 1'b0;
        end else begin
            frameClearReq <= pulseVec[ACT_HFC];
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            busResetReq <= 1'b0;
        end else begin
            busResetReq <= pulseVec[ACT_BDR];
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            coreResetReq <= 1'b0;
        end else begin
            coreResetReq <= pulseVec[ACT_CSR];
        end
    end

    // =====================================================================
    // Read-back
    // =====================================================================
    // Trigger bits read back as busy flags; reserved bits 31:11 and 3 read zero
    // Selector reads back as written, even while a flush using it runs
    always_comb begin
        rdWord = '0;
        rdWord[UGRC_SEL_MSB:UGRC_SEL_LSB] = txSel_r;
        rdWord[UGRC_TXF_BIT] = busyVec[ACT_TX];
        rdWord[UGRC_RXF_BIT] = busyVec[ACT_RX];
        rdWord[UGRC_HFC_BIT] = busyVec[ACT_HFC];
        rdWord[UGRC_BDR_BIT] = busyVec[ACT_BDR];
        rdWord[UGRC_CSR_BIT] = busyVec[ACT_CSR];
    end

    // Data stand for the one cycle after the strobe and are zero otherwise
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            rdData_r <= 32'h0000_0000;
        end else if (rdHit) begin
            rdData_r <= rdWord;
        end else begin
            rdData_r <= 32'h0000_0000;
        end
    end

    assign rdData = rdData_r;
endmodule // ugrc_core
`default_nettype wire

// ==== testbench/ugrc_core_assertions.sv ====
// Checker for the global reset control register ports
`timescale 1ns/1ps
`default_nettype none
module ugrc_core_assertions
    import ugrc_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Register port
    input wire logic [11:0] addr,
    input wire logic [31:0] wrData,
    input wire logic wrStb,
    input wire logic [31:0] rdData,
    // Mode
    input wire logic hostMode,
    // Requests
    input wire logic hostNonPerFlush,
    input wire logic hostPerFlush,
    input wire logic rxFlushReq,
    input wire logic frameClearReq,
    input wire logic busResetReq,
    input wire logic coreResetReq,
    input wire logic [3:0] devTxFifoFlush
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    a_rd_reserved: assert property (rdData[31:11] == 21'h0 && !rdData[3])
        else $error("reserved bits read non-zero");
    a_rx_cause: assert property (rxFlushReq |-> $past(wrStb && wrData[UGRC_RXF_BIT], 2))
        else $error("rx request without write");
    a_rx_once: assert property (rxFlushReq |=> !rxFlushReq)
        else $error("rx request too long");
    a_tx_host: assert property ((hostNonPerFlush || hostPerFlush) |->
        $past(hostMode && wrStb && wrData[UGRC_TXF_BIT], 2))
        else $error("host tx flush without write");
    a_dev_shape: assert property ((|devTxFifoFlush) |->
        ($onehot(devTxFifoFlush) || devTxFifoFlush == 4'hF) && !hostMode)
        else $error("bad device flush set");
    a_dev_cause: assert property ((|devTxFifoFlush) |->
        $past(!hostMode && wrStb && addr == UGRC_GLOBAL_RESET_CONTROL_OFS
        && wrData[UGRC_TXF_BIT], 2))
        else $error("device tx flush without write");
    a_frame_host: assert property (frameClearReq |->
        $past(hostMode && wrStb && wrData[UGRC_HFC_BIT], 2))
        else $error("frame clear not from host write");
    a_bus_cause: assert property (busResetReq |-> $past(wrStb && wrData[UGRC_BDR_BIT], 2))
        else $error("bus reset without write");
    a_core_cause: assert property (coreResetReq |-> $past(wrStb && wrData[UGRC_CSR_BIT], 2))
        else $error("core reset without write");
    a_core_once: assert property (coreResetReq |=> !coreResetReq)
        else $error("core reset request too long");
endmodule // ugrc_core_assertions
bind ugrc_core ugrc_core_assertions u_chk(.clock(clock), .rst_n(rst_n), .addr(addr), .wrStb(wrStb),
    .hostMode(hostMode), .wrData(wrData), .rdData(rdData), .hostNonPerFlush(hostNonPerFlush),
    .hostPerFlush(hostPerFlush), .rxFlushReq(rxFlushReq), .frameClearReq(frameClearReq),
    .busResetReq(busResetReq), .coreResetReq(coreResetReq), .devTxFifoFlush(devTxFifoFlush));
`default_nettype wire

// ==== testbench/tb_top.sv ====
// Self-checking bench for the global reset control register
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import ugrc_pkg::*;
    logic clock, rst_n, wrStb, rdStb, hostMode, rdPend, clrSeen, hNp, hP, rxR, fcR, brR, crR;
    logic [11:0] addr;
    logic [31:0] wrData, rdData;
    logic [4:0] done, s;
    logic [3:0] dev;
    logic [9:0] seen;
    logic [31:0] expQ[$];
    logic [4:0] tbl[10] = '{5'h00, 5'h01, 5'h10, 5'h05, 5'h00, 5'h01, 5'h02, 5'h03, 5'h1F, 5'h04};
    int errors, n_compared;
    ugrc_core u_ugrc_core(.clock(clock), .rst_n(rst_n), .addr(addr), .wrData(wrData),
        .wrStb(wrStb), .rdStb(rdStb), .rdData(rdData), .hostMode(hostMode),
        .txFlushDone(done[4]), .rxFlushDone(done[3]), .frameClearDone(done[2]),
        .busResetDone(done[1]), .coreResetDone(done[0]), .hostNonPerFlush(hNp),
        .hostPerFlush(hP), .devTxFifoFlush(dev), .rxFlushReq(rxR), .frameClearReq(fcR),
        .busResetReq(brR), .coreResetReq(crR));
    initial begin
        clock = 0;
        forever #20 clock = ~clock;
    end
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task report_and_stop;
        $display("errors %0d compared %0d", errors, n_compared);
        if (errors == 0 && n_compared > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // Read data stands only in the cycle after the strobe
    always @(posedge clock) begin
        rdPend <= rdStb;
        seen <= clrSeen ? 10'h0 : seen | {hNp, hP, dev, rxR, fcR, brR, crR};
        if (rdPend) chk(rdData, expQ.pop_front());
    end
    task bus(input logic w, input logic [11:0] a, input logic [31:0] d);
        // Full word transfers only
        @(posedge clock);
        addr <= a;
        wrData <= d;
        wrStb <= w;
        rdStb <= !w;
        if (!w) expQ.push_back(d);
        @(posedge clock);
        wrStb <= 1'b0;
        rdStb <= 1'b0;
    endtask
    task trig(input logic [31:0] d, input logic host);
        logic [9:0] e;
        s = d[10:6];
        e[9] = host && d[5] && (s == 5'h00 || s[4]);
        e[8] = host && d[5] && (s == 5'h01 || s[4]);
        e[7:4] = (host || !d[5]) ? 4'h0 : s[4] ? 4'hF : (s < 5'h04) ? 4'(1 << s) : 4'h0;
        e[3:0] = {d[4], d[2] && host, d[1:0]};
        hostMode <= host;
        clrSeen <= 1'b1;
        @(posedge clock);
        clrSeen <= 1'b0;
        bus(1'b1, UGRC_GLOBAL_RESET_CONTROL_OFS, d);
        bus(1'b0, UGRC_GLOBAL_RESET_CONTROL_OFS, {21'h0, s, d[5:4], 1'b0, e[2:0]});
        // Zeros while busy must not cut a running action short
        bus(1'b1, UGRC_GLOBAL_RESET_CONTROL_OFS, {21'h0, s, 6'h0});
        bus(1'b0, UGRC_GLOBAL_RESET_CONTROL_OFS, {21'h0, s, d[5:4], 1'b0, e[2:0]});
        repeat (2) @(posedge clock);
        chk({22'h0, seen}, {22'h0, e});
        done <= 5'h1F;
        @(posedge clock);
        done <= 5'h00;
        bus(1'b0, UGRC_GLOBAL_RESET_CONTROL_OFS, {21'h0, s, 6'h0});
    endtask
    initial begin
        errors = 0;
        n_compared = 0;
        {rst_n, wrStb, rdStb, hostMode, clrSeen} = 5'h01;
        addr = 12'h000;
        wrData = 32'h0;
        done = 5'h00;
        void'($urandom(88531));
        repeat (12) @(posedge clock);
        rst_n <= 1'b1;
        bus(1'b0, UGRC_GLOBAL_RESET_CONTROL_OFS, 32'h0);
        bus(1'b0, 12'h014, 32'h0);
        for (int i = 0; i < 12; i++) begin
            s = (i < 10) ? tbl[i] : 5'($urandom);
            trig({21'h0, s, 1'b1, i[0], 1'b0, i[1], i[2], 1'b0}, i < 4 || i > 10);
        end
        trig(32'h1, 1'b1);
        // No acknowledge: the busy bit must still fall after the fixed timeout
        bus(1'b1, UGRC_GLOBAL_RESET_CONTROL_OFS, 32'h0000_0010);
        repeat (200) @(posedge clock);
        bus(1'b0, UGRC_GLOBAL_RESET_CONTROL_OFS, 32'h0000_0010);
        repeat (56) @(posedge clock);
        bus(1'b0, UGRC_GLOBAL_RESET_CONTROL_OFS, 32'h0);
        // Reset in mid-flush drops the trigger bit and the selector
        bus(1'b1, UGRC_GLOBAL_RESET_CONTROL_OFS, 32'h0000_07E0);
        rst_n <= 1'b0;
        @(posedge clock);
        rst_n <= 1'b1;
        bus(1'b0, UGRC_GLOBAL_RESET_CONTROL_OFS, 32'h0);
        // Let the last read data reach the watcher before the verdict
        repeat (2) @(posedge clock);
        report_and_stop;
    end
    initial begin
        repeat (5000) @(posedge clock);
        errors++;
        report_and_stop;
    end
endmodule // tb_top
`default_nettype wire
